// ### rtl/urs_pkg.sv
// Package for the UART register-select block: offsets, fields, reset values and timing
// Operation
// - Target register chosen from address code plus gating bits in other registers.
// - Base code 000 reads receive holding data, writes load transmit holding FIFO.
// - Base code 010 reads interrupt identification, writes go to FIFO control.
// - Base codes 101 and 110 read line and modem status; no write.
// - Codes 001, 011, 100, 111 hold int enable, line control, modem control, scratch.
// - Divisor low at 000, high at 001, forming sixteen-bit read/write divisor.
// - Divisor bytes replace codes 000 and 001 only while line control bit 7 set.
// - Enhanced bank visible only while line control equals 0xBF.
// - Enhanced bank: feature at 010, resume chars 100/101, pause chars 110/111.
// - Threshold and trigger registers visible only when feature bit 4 and modem bit 6.
// - Threshold register at 110, trigger level at 111, both read/write.
// - FIFO ready summary at 111 when a select low, modem bit2 set, loopback clear.
// - Summary bits 0-3 transmit status A-D, bits 4-7 receive status A-D.
// - Writes to modem control bit 7 ignored unless feature bit 4 set.
// - Upper int enable, transmit trigger and upper modem bits protected unless feature bit 4.
// - Divide factor cleared by reset, taken from tie-off on first enabled clock after reset, later changed by modem bit 7.
package urs_pkg;
    localparam logic [2:0] ADDR_HOLD = 3'h0;
    localparam logic [2:0] ADDR_IEN = 3'h1;
    localparam logic [2:0] ADDR_IDENT = 3'h2;
    localparam logic [2:0] ADDR_LCTL = 3'h3;
    localparam logic [2:0] ADDR_MCTL = 3'h4;
    localparam logic [2:0] ADDR_LSTAT = 3'h5;
    localparam logic [2:0] ADDR_MSTAT = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;
    localparam logic [7:0] LCTL_ENH_KEY = 8'hBF;
    localparam int LCTL_DIV_BIT = 7;
    localparam int FEAT_ENH_BIT = 4;
    localparam int MCTL_PRESCALE_BIT = 7;
    localparam int MCTL_THRESH_BIT = 6;
    localparam int MCTL_LOOP_BIT = 4;
    localparam int MCTL_RDYSUM_BIT = 2;
    // Bits writable only with enhanced functions on
    localparam logic [7:0] IEN_PROT_MASK = 8'hF0;
    localparam logic [7:0] FCTL_PROT_MASK = 8'h30;
    localparam logic [7:0] MCTL_PROT_MASK = 8'hE0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    localparam int PRESCALE_DIV4 = 4;
    localparam int PRESCALE_DIV1 = 1;
    localparam int WAIT_MULT = 4;
    localparam int WAIT_W = 24;

    typedef enum logic [1:0] {
        URS_BANK_BASE = 2'b00,
        URS_BANK_DIV = 2'b01,
        URS_BANK_ENH = 2'b11,
        URS_BANK_THR = 2'b10
    } urs_bank_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] data;
    } urs_req_t;

    typedef struct packed {
        logic [3:0] rxRdy;
        logic [3:0] txRdy;
    } urs_rdy_t;
endpackage

// ### rtl/urs_reg_select.sv
// Register selection, access gating and transmit pacing for one UART channel
`timescale 1ns/1ps
module urs_reg_select import urs_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire urs_req_t hostReq,
    input wire logic [3:0] chanSelN,
    input wire logic prescaleTieoff,
    input wire logic [7:0] rxHolding,
    input wire logic [7:0] intIdent,
    input wire logic [7:0] lineStatus,
    input wire logic [7:0] modemStatus,
    input wire urs_rdy_t fifo_ready_summary,
    input wire logic txFifoEmpty,
    output logic [7:0] rdData,
    output logic txWrite,
    output logic [7:0] txData,
    output logic fcWrite,
    output logic [7:0] fifoControl,
    output logic [7:0] intEnable,
    output logic [7:0] lineControl,
    output logic [7:0] modemControl,
    output logic [15:0] divisor,
    output logic [7:0] enhancedFeature,
    output logic [7:0] flowThreshold,
    output logic [7:0] triggerLevel,
    output logic prescaleDiv4,
    output logic txPaceBusy
);
    logic [7:0] ienQ, ienD, lctlQ, lctlD, mctlQ, mctlD, scrQ, scrD;
    logic [7:0] divLoQ, divLoD, divHiQ, divHiD, featQ, featD;
    logic [7:0] res1Q, res1D, res2Q, res2D, pau1Q, pau1D, pau2Q, pau2D;
    logic [7:0] thrQ, thrD, tlvQ, tlvD, fctlQ, fctlD, rdQ, rdD, txDatQ, txDatD;
    logic txWrQ, txWrD, fcWrQ, fcWrD, psQ, psD, strapDoneQ, strapDoneD;
    logic [WAIT_W-1:0] waitQ, waitD;
    logic [1:0] chanSyncQ [4];
    logic [1:0] tieSyncQ;
    logic [3:0] chanSelSync;
    logic enhOn, divVis, enhVis, thrVis, rdySumVis, wrStb, rdStb;
    logic [7:0] wdat;
    urs_bank_t bank;

    // Pin synchronisers, two stages each
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                chanSyncQ[i] <= 2'h3;
            end
        end else if (clkEn) begin
            for (int i = 0; i < 4; i++) begin
                chanSyncQ[i] <= {chanSyncQ[i][0], chanSelN[i]};
            end
        end
    end

    // Tie-off sampler keeps running through reset
    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            tieSyncQ <= {tieSyncQ[0], prescaleTieoff};
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chanSelSync[i] = chanSyncQ[i][1];
        end
    end

    assign wrStb = hostReq.wr;
    assign rdStb = hostReq.rd;
    assign wdat = hostReq.data;
    assign enhOn = featQ[FEAT_ENH_BIT];

    assign divVis = lctlQ[LCTL_DIV_BIT];
    assign enhVis = (lctlQ == LCTL_ENH_KEY);
    assign thrVis = enhOn && mctlQ[MCTL_THRESH_BIT];
    assign rdySumVis = (chanSelSync != 4'hF) && mctlQ[MCTL_RDYSUM_BIT] && !mctlQ[MCTL_LOOP_BIT];

    always_comb begin
        if (enhVis) begin
            bank = URS_BANK_ENH;
        end else if (divVis) begin
            bank = URS_BANK_DIV;
        end else if (thrVis) begin
            bank = URS_BANK_THR;
        end else begin
            bank = URS_BANK_BASE;
        end
    end

    // Register writes
    always_comb begin
        ienD = ienQ;
        lctlD = lctlQ;
        mctlD = mctlQ;
        scrD = scrQ;
        divLoD = divLoQ;
        divHiD = divHiQ;
        featD = featQ;
        res1D = res1Q;
        res2D = res2Q;
        pau1D = pau1Q;
        pau2D = pau2Q;
        thrD = thrQ;
        tlvD = tlvQ;
        fctlD = fctlQ;
        txDatD = txDatQ;
        txWrD = 1'b0;
        fcWrD = 1'b0;
        if (wrStb) begin
            case (hostReq.addr)
                ADDR_HOLD: begin
                    if (bank == URS_BANK_DIV || bank == URS_BANK_ENH) begin
                        divLoD = wdat;
                    end else begin
                        txDatD = wdat;
                        txWrD = 1'b1;
                    end
                end
                ADDR_IEN: begin
                    if (bank == URS_BANK_DIV || bank == URS_BANK_ENH) begin
                        divHiD = wdat;
                    end else begin
                        ienD = enhOn ? wdat : ((wdat & ~IEN_PROT_MASK) | (ienQ & IEN_PROT_MASK));
                    end
                end
                ADDR_IDENT: begin
                    if (bank == URS_BANK_ENH) begin
                        featD = wdat;
                    end else begin
                        fctlD = enhOn ? wdat : ((wdat & ~FCTL_PROT_MASK) | (fctlQ & FCTL_PROT_MASK));
                        fcWrD = 1'b1;
                    end
                end
                ADDR_LCTL: begin
                    lctlD = wdat;
                end
                ADDR_MCTL: begin
                    if (bank == URS_BANK_ENH) begin
                        res1D = wdat;
                    end else begin
                        mctlD = enhOn ? wdat : ((wdat & ~MCTL_PROT_MASK) | (mctlQ & MCTL_PROT_MASK));
                    end
                end
                ADDR_LSTAT: begin
                    if (bank == URS_BANK_ENH) begin
                        res2D = wdat;
                    end
                end
                ADDR_MSTAT: begin
                    if (bank == URS_BANK_ENH) begin
                        pau1D = wdat;
                    end else if (bank == URS_BANK_THR) begin
                        thrD = wdat;
                    end
                end
                ADDR_SCRATCH: begin
                    if (bank == URS_BANK_ENH) begin
                        pau2D = wdat;
                    end else if (bank == URS_BANK_THR) begin
                        tlvD = wdat;
                    end else begin
                        scrD = wdat;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux
    always_comb begin
        rdD = rdQ;
        if (rdStb) begin
            case (hostReq.addr)
                ADDR_HOLD: rdD = (bank == URS_BANK_DIV || bank == URS_BANK_ENH) ? divLoQ : rxHolding;
                ADDR_IEN: rdD = (bank == URS_BANK_DIV || bank == URS_BANK_ENH) ? divHiQ : ienQ;
                ADDR_IDENT: rdD = (bank == URS_BANK_ENH) ? featQ : intIdent;
                ADDR_LCTL: rdD = lctlQ;
                ADDR_MCTL: rdD = (bank == URS_BANK_ENH) ? res1Q : mctlQ;
                ADDR_LSTAT: rdD = (bank == URS_BANK_ENH) ? res2Q : lineStatus;
                ADDR_MSTAT: begin
                    if (bank == URS_BANK_ENH) begin
                        rdD = pau1Q;
                    end else if (bank == URS_BANK_THR) begin
                        rdD = thrQ;
                    end else begin
                        rdD = modemStatus;
                    end
                end
                ADDR_SCRATCH: begin
                    if (bank == URS_BANK_ENH) begin
                        rdD = pau2Q;
                    end else if (bank == URS_BANK_THR) begin
                        rdD = tlvQ;
                    end else if (rdySumVis) begin
                        rdD = {fifo_ready_summary.rxRdy, fifo_ready_summary.txRdy};
                    end else begin
                        rdD = scrQ;
                    end
                end
                default: rdD = 8'h00;
            endcase
        end
    end

    // Prescale from tie-off, then modem bit 7
    always_comb begin
        strapDoneD = 1'b1;
        psD = psQ;
        if (!strapDoneQ) begin
            psD = tieSyncQ[1];
        end else if (mctlD[MCTL_PRESCALE_BIT] != mctlQ[MCTL_PRESCALE_BIT]) begin
            psD = mctlD[MCTL_PRESCALE_BIT];
        end
    end

    // Host pacing window after first write to empty FIFO
    always_comb begin
        logic [WAIT_W-1:0] span;
        span = WAIT_W'(({8'h00, divHiQ, divLoQ}) * WAIT_W'(WAIT_MULT)
            * WAIT_W'(psQ ? PRESCALE_DIV4 : PRESCALE_DIV1));
        waitD = waitQ;
        if (txWrD && txFifoEmpty && waitQ == '0) begin
            waitD = span;
        end else if (waitQ != '0) begin
            waitD = waitQ - WAIT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ienQ <= REG_RESET;
            lctlQ <= REG_RESET;
            mctlQ <= REG_RESET;
            scrQ <= REG_RESET;
            divLoQ <= DIV_RESET[7:0];
            divHiQ <= DIV_RESET[15:8];
            featQ <= REG_RESET;
            res1Q <= REG_RESET;
            res2Q <= REG_RESET;
            pau1Q <= REG_RESET;
            pau2Q <= REG_RESET;
            thrQ <= REG_RESET;
            tlvQ <= REG_RESET;
            fctlQ <= REG_RESET;
            txDatQ <= REG_RESET;
            rdQ <= REG_RESET;
            txWrQ <= 1'b0;
            fcWrQ <= 1'b0;
            psQ <= 1'b0;
            strapDoneQ <= 1'b0;
            waitQ <= '0;
        end else if (clkEn) begin
            ienQ <= ienD;
            lctlQ <= lctlD;
            mctlQ <= mctlD;
            scrQ <= scrD;
            divLoQ <= divLoD;
            divHiQ <= divHiD;
            featQ <= featD;
            res1Q <= res1D;
            res2Q <= res2D;
            pau1Q <= pau1D;
            pau2Q <= pau2D;
            thrQ <= thrD;
            tlvQ <= tlvD;
            fctlQ <= fctlD;
            txDatQ <= txDatD;
            rdQ <= rdD;
            txWrQ <= txWrD;
            fcWrQ <= fcWrD;
            psQ <= psD;
            strapDoneQ <= strapDoneD;
            waitQ <= waitD;
        end
    end

    assign rdData = rdQ;
    assign txWrite = txWrQ;
    assign txData = txDatQ;
    assign fcWrite = fcWrQ;
    assign fifoControl = fctlQ;
    assign intEnable = ienQ;
    assign lineControl = lctlQ;
    assign modemControl = mctlQ;
    assign divisor = {divHiQ, divLoQ};
    assign enhancedFeature = featQ;
    assign flowThreshold = thrQ;
    assign triggerLevel = tlvQ;
    assign prescaleDiv4 = psQ;
    assign txPaceBusy = (waitQ != '0);

    sequence lctlKeyed_s;
        lctlQ == LCTL_ENH_KEY;
    endsequence

    sequence featWrite_s;
        clkEn && wrStb && hostReq.addr == ADDR_IDENT;
    endsequence

    featWriteLands_a: assert property (@(posedge ref_clk) disable iff (rst)
        lctlKeyed_s and featWrite_s |=> featQ == $past(wdat))
        else $error("feature register write lost");
    // FIFO control write in base bank
    fctlWriteStrobe_a: assert property (@(posedge ref_clk) disable iff (rst)
        featWrite_s and !lctlQ[LCTL_DIV_BIT] |=> fcWrite && !$changed(featQ))
        else $error("fifo control write not strobed");
    txLoad_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_HOLD && !lctlQ[LCTL_DIV_BIT] |=> txWrite && txData == $past(wdat))
        else $error("transmit load missing");
    divLowWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_HOLD && lctlQ[LCTL_DIV_BIT] |=> !txWrite && divisor[7:0] == $past(wdat))
        else $error("divisor low write wrong");
    prescaleGuard_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !enhOn |=> $stable(mctlQ[MCTL_PRESCALE_BIT]))
        else $error("prescale bit changed while protected");
    ienGuard_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !enhOn |=> (intEnable & IEN_PROT_MASK) == ($past(intEnable) & IEN_PROT_MASK))
        else $error("protected enable bits changed");
    // No write at line status code outside enhanced bank
    statusNoWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_LSTAT && lctlQ != LCTL_ENH_KEY |=> $stable(res2Q) && $stable(lctlQ))
        else $error("status location accepted a write");
    rdySummary_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && rdStb && hostReq.addr == ADDR_SCRATCH && bank == URS_BANK_BASE && rdySumVis
        |=> rdData == $past({fifo_ready_summary.rxRdy, fifo_ready_summary.txRdy}))
        else $error("fifo ready summary wrong");
    paceCount_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && waitQ > WAIT_W'(1) |=> txPaceBusy)
        else $error("pacing window ended early");
    thrWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_MSTAT && bank == URS_BANK_THR |=> flowThreshold == $past(wdat))
        else $error("threshold write lost");
    thrHidden_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !(enhOn && mctlQ[MCTL_THRESH_BIT]) |=> $stable(thrQ) && $stable(tlvQ))
        else $error("threshold register changed while hidden");
    strapLoad_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && !strapDoneQ |=> prescaleDiv4 == $past(tieSyncQ[1]))
        else $error("prescale not taken from tie-off");
    divHighWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_IEN && lctlQ[LCTL_DIV_BIT] |=> divisor[15:8] == $past(wdat))
        else $error("divisor high write wrong");
    absentWrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && wrStb && hostReq.addr == ADDR_MSTAT && bank == URS_BANK_BASE |=> $stable(thrQ) && $stable(pau1Q))
        else $error("write to absent location changed state");
endmodule // urs_reg_select

// ### tb/urs_host_model.sv
// Host processor model that drives the parallel register bus of the channel
`timescale 1ns/1ps
module urs_host_model import urs_pkg::*; (
    input wire logic ref_clk,
    input wire logic txPaceBusy,
    input wire logic [7:0] rdData,
    output urs_req_t hostReq
);
    initial begin
        hostReq = '0;
    end

    // Released address and data lines show the inverse of the last value, never a stale copy
    task automatic release_bus();
        hostReq <= '{rd: 1'b0, wr: 1'b0, addr: ~hostReq.addr, data: ~hostReq.data};
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        // pacing after first byte, a hang is caught by the bench watchdog
        while (a == ADDR_HOLD && txPaceBusy === 1'b1) begin
            @(posedge ref_clk);
        end
        @(posedge ref_clk);
        hostReq <= '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
        @(posedge ref_clk);
        release_bus();
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        hostReq <= '{rd: 1'b1, wr: 1'b0, addr: a, data: ~hostReq.data};
        @(posedge ref_clk);
        release_bus();
        #1;
        d = rdData;
    endtask
endmodule // urs_host_model

// ### tb/testbench.sv
// Self-checking bench for the register-select block with a host bus model
`timescale 1ns/1ps
module testbench import urs_pkg::*;;
    logic ref_clk, rst, clkEn, prescaleTieoff, txFifoEmpty;
    logic [3:0] chanSelN;
    logic [7:0] rxHolding, intIdent, lineStatus, modemStatus;
    urs_req_t hostReq;
    urs_rdy_t fifo_ready_summary;
    logic [7:0] rdData, txData, fifoControl, intEnable, lineControl, modemControl;
    logic [7:0] enhancedFeature, flowThreshold, triggerLevel;
    logic [15:0] divisor;
    logic txWrite, fcWrite, prescaleDiv4, txPaceBusy;
    int n_errors = 0;
    int tests_run = 0;

    urs_reg_select u_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .hostReq(hostReq),
        .chanSelN(chanSelN), .prescaleTieoff(prescaleTieoff), .rxHolding(rxHolding),
        .intIdent(intIdent), .lineStatus(lineStatus), .modemStatus(modemStatus),
        .fifo_ready_summary(fifo_ready_summary), .txFifoEmpty(txFifoEmpty), .rdData(rdData), .txWrite(txWrite),
        .txData(txData), .fcWrite(fcWrite), .fifoControl(fifoControl), .intEnable(intEnable),
        .lineControl(lineControl), .modemControl(modemControl), .divisor(divisor),
        .enhancedFeature(enhancedFeature), .flowThreshold(flowThreshold),
        .triggerLevel(triggerLevel), .prescaleDiv4(prescaleDiv4), .txPaceBusy(txPaceBusy));

    urs_host_model u_host (.ref_clk(ref_clk), .txPaceBusy(txPaceBusy), .rdData(rdData),
        .hostReq(hostReq));

    initial begin
        ref_clk = 1'b0;
        forever begin
            #25 ref_clk = ~ref_clk;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic test_reset();
        check({intEnable, lineControl}, 16'h0000, "ien lctl reset");
        check({modemControl, enhancedFeature}, 16'h0000, "mctl feat reset");
        check({flowThreshold, triggerLevel}, 16'h0000, "thr tlr reset");
        check(divisor, 16'h0000, "divisor reset");
        check(prescaleDiv4, 16'h0000, "prescale from tie-off");
        $display("test reset done");
    endtask

    task automatic test_base();
        logic [7:0] r;
        u_host.rd(ADDR_HOLD, r);
        check(r, 8'h3C, "rx holding read");
        u_host.rd(ADDR_IDENT, r);
        check(r, 8'hC1, "ident read");
        u_host.wr(ADDR_HOLD, 8'h55);
        check({txWrite, txData}, 16'h0155, "tx load");
        u_host.wr(ADDR_IDENT, 8'hFF);
        check({fcWrite, txWrite, fifoControl}, 16'h02CF, "fifo ctl protected");
        u_host.wr(ADDR_IEN, 8'hFF);
        check(intEnable, 8'h0F, "ien protected");
        u_host.wr(ADDR_MCTL, 8'hFB);
        check({modemControl, 7'h00, prescaleDiv4}, 16'h1B00, "mctl protected");
        u_host.wr(ADDR_LSTAT, 8'hAA);
        u_host.wr(ADDR_MSTAT, 8'hAA);
        check({intEnable, lineControl}, 16'h0F00, "ro write ignored");
        check({modemControl, enhancedFeature}, 16'h1B00, "ro write ignored");
        u_host.rd(ADDR_LSTAT, r);
        check(r, 8'h60, "line status");
        u_host.rd(ADDR_MSTAT, r);
        check(r, 8'hB2, "modem status");
        u_host.wr(ADDR_SCRATCH, 8'h96);
        u_host.rd(ADDR_SCRATCH, r);
        check(r, 8'h96, "scratch");
        u_host.rd(ADDR_IEN, r);
        check(r, 8'h0F, "ien read");
        u_host.rd(ADDR_MCTL, r);
        check(r, 8'h1B, "mctl read");
        $display("test base done");
    endtask

    task automatic test_divisor();
        logic [7:0] r;
        u_host.wr(ADDR_LCTL, 8'h80);
        u_host.wr(ADDR_HOLD, 8'h34);
        check(txWrite, 1'h0, "no tx load in divisor bank");
        u_host.wr(ADDR_IEN, 8'h12);
        check(divisor, 16'h1234, "divisor pair");
        check(intEnable, 8'h0F, "ien kept in divisor bank");
        u_host.rd(ADDR_HOLD, r);
        check(r, 8'h34, "divisor low read");
        u_host.rd(ADDR_IEN, r);
        check(r, 8'h12, "divisor high read");
        u_host.rd(ADDR_IDENT, r);
        check(r, 8'hC1, "ident in divisor bank");
        u_host.wr(ADDR_LCTL, 8'h03);
        u_host.rd(ADDR_HOLD, r);
        check(r, 8'h3C, "base bank again");
        u_host.wr(ADDR_LCTL, 8'h00);
        $display("test divisor done");
    endtask

    task automatic test_enhanced();
        logic [7:0] r;
        u_host.wr(ADDR_LCTL, 8'hBF);
        u_host.wr(ADDR_IDENT, 8'h10);
        check({fcWrite, enhancedFeature}, 16'h0010, "feature write");
        for (int k = 4; k < 8; k++) begin
            u_host.wr(3'(k), 8'hA0 + 8'(k));
        end
        for (int k = 4; k < 8; k++) begin
            u_host.rd(3'(k), r);
            check(r, 8'hA0 + 8'(k), "flow character");
        end
        u_host.rd(ADDR_IDENT, r);
        check(r, 8'h10, "feature read");
        u_host.wr(ADDR_LCTL, 8'h00);
        u_host.rd(ADDR_MCTL, r);
        check(r, 8'h1B, "enhanced bank closed");
        $display("test enhanced done");
    endtask

    task automatic test_threshold();
        logic [7:0] r;
        u_host.wr(ADDR_IEN, 8'hFF);
        check(intEnable, 8'hFF, "ien unprotected");
        u_host.wr(ADDR_IDENT, 8'hFF);
        check(fifoControl, 8'hFF, "fifo ctl unprotected");
        u_host.wr(ADDR_MCTL, 8'hC0);
        u_host.wr(ADDR_MSTAT, 8'h5A);
        u_host.wr(ADDR_SCRATCH, 8'hA5);
        check({modemControl, 7'h00, prescaleDiv4}, 16'hC001, "prescale by write");
        check({flowThreshold, triggerLevel}, 16'h5AA5, "threshold regs");
        u_host.rd(ADDR_MSTAT, r);
        check(r, 8'h5A, "threshold read");
        u_host.rd(ADDR_SCRATCH, r);
        check(r, 8'hA5, "trigger read");
        u_host.wr(ADDR_MCTL, 8'h04);
        u_host.rd(ADDR_MSTAT, r);
        check({r, 7'h00, prescaleDiv4}, 16'hB200, "threshold bank closed");
        $display("test threshold done");
    endtask

    task automatic test_summary();
        logic [7:0] r;
        @(posedge ref_clk);
        chanSelN <= 4'hD;
        repeat (4) @(posedge ref_clk);
        u_host.rd(ADDR_SCRATCH, r);
        check(r, 8'hA5, "ready summary");
        u_host.wr(ADDR_MCTL, 8'h14);
        u_host.rd(ADDR_SCRATCH, r);
        check(r, 8'h96, "loopback hides summary");
        u_host.wr(ADDR_MCTL, 8'h04);
        @(posedge ref_clk);
        chanSelN <= 4'hF;
        repeat (4) @(posedge ref_clk);
        u_host.rd(ADDR_SCRATCH, r);
        check(r, 8'h96, "no select hides summary");
        $display("test summary done");
    endtask

    task automatic test_pacing();
        int busy;
        u_host.wr(ADDR_LCTL, 8'h80);
        u_host.wr(ADDR_HOLD, 8'h03);
        u_host.wr(ADDR_IEN, 8'h00);
        u_host.wr(ADDR_LCTL, 8'h00);
        @(posedge ref_clk);
        txFifoEmpty <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            u_host.wr(ADDR_MCTL, p == 1 ? 8'h84 : 8'h04);
            u_host.wr(ADDR_HOLD, 8'h77);
            busy = 0;
            // First sample falls in the cycle right after the loading edge
            for (int c = 0; c < 70; c++) begin
                busy += (txPaceBusy === 1'b1) ? 1 : 0;
                @(posedge ref_clk);
                #1;
            end
            check(16'(busy), p == 1 ? 16'h0030 : 16'h000C, "pace length");
        end
        u_host.wr(ADDR_HOLD, 8'h77);
        u_host.wr(ADDR_HOLD, 8'h88);
        check({txWrite, txData}, 16'h0188, "paced second byte");
        $display("test pacing done");
    endtask

    task automatic test_midreset();
        @(posedge ref_clk);
        prescaleTieoff <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check({prescaleDiv4, txPaceBusy, 6'h00, modemControl}, 16'h8000, "tie-off after reset");
        check({intEnable, enhancedFeature}, 16'h0000, "registers after reset");
        u_host.wr(ADDR_MCTL, 8'h80);
        check({modemControl, 7'h00, prescaleDiv4}, 16'h0001, "prescale write protected");
        $display("test midreset done");
    endtask

    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        prescaleTieoff = 1'b0;
        txFifoEmpty = 1'b0;
        chanSelN = 4'hF;
        rxHolding = 8'h3C;
        intIdent = 8'hC1;
        lineStatus = 8'h60;
        modemStatus = 8'hB2;
        fifo_ready_summary = '{rxRdy: 4'hA, txRdy: 4'h5};
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        test_reset();
        test_base();
        test_divisor();
        test_enhanced();
        test_threshold();
        test_summary();
        test_pacing();
        test_midreset();
        final_report();
    end

    initial begin
        #(5000 * 50);
        n_errors++;
        final_report();
    end
endmodule // testbench
